/* tlic_core_model.sv */
// Core stand-in: instruction boundaries, return address, return pulses
`timescale 1ns/1ps
`default_nettype none
module tlic_core_model
  import tlic_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic srst, // Sync reset
  input wire logic slow, // Two-cycle instructions
  input wire logic ret_req, // Bench asks for a return
  input wire logic irq_take, // Vector taken
  input wire logic [PC_W-1:0] vector_addr, // Vector address
  output logic instr_done, // Instruction boundary
  output logic [PC_W-1:0] ret_addr, // Next instruction
  output logic ret_pulse // Return executed
);
  logic half_ff;
  logic pend_ff;
  // Slow mode ends an instruction every other cycle only
  assign instr_done = !slow || half_ff;
  always_ff @(posedge clk) begin
    if (srst) half_ff <= 1'b0;
    else half_ff <= !half_ff;
  end
  always_ff @(posedge clk) begin
    if (srst) ret_addr <= 21'h000100;
    else if (irq_take) ret_addr <= vector_addr;
    else if (instr_done) ret_addr <= ret_addr + 21'h000002;
  end
  always_ff @(posedge clk) begin
    if (srst) pend_ff <= 1'b0;
    else if (ret_req) pend_ff <= 1'b1;
    else if (ret_pulse) pend_ff <= 1'b0;
  end
  // Return only at a boundary, one cycle wide
  always_ff @(posedge clk) begin
    if (srst) ret_pulse <= 1'b0;
    else ret_pulse <= pend_ff && instr_done && !ret_pulse;
  end
endmodule
`default_nettype wire

/* tlic_edge_det.sv */
// Synchroniser and selectable edge detector for one external pin
`timescale 1ns/1ps
`default_nettype none
module tlic_edge_det
  import tlic_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic srst, // Sync reset
  input wire logic ce, // Clock enable
  input wire logic pin, // Raw pin level
  input wire logic rise_sel, // 1 rising, 0 falling
  output logic edge_pulse // One-cycle event
);
  logic [SYNC_STAGES-1:0] sync_ff;
  logic last_ff;

  always_ff @(posedge clk) begin
    if (srst) begin
      sync_ff <= '0;
      last_ff <= 1'b0;
    end else if (ce) begin
      sync_ff <= {sync_ff[SYNC_STAGES-2:0], pin};
      last_ff <= sync_ff[SYNC_STAGES-1];
    end
  end

  // Edge chosen by select; only the last stage is looked at
  assign edge_pulse = ce & (rise_sel ?
    (sync_ff[SYNC_STAGES-1] & ~last_ff) :
    (~sync_ff[SYNC_STAGES-1] & last_ff));
endmodule
`default_nettype wire

/* tlic_pkg.sv */
// Constants, register map and types of the two-level interrupt controller
// Notes on behaviour
// - High-level requests vector to 0008h, low-level requests to 0018h.
// - High request preempts low service; low waits while high service runs.
// - Every source has an event flag, an enable and a priority bit.
// - Two-level priority works only while priority-mode enable bit 7 is set.
// - Priority mode: bit 7 gates high sources, bit 6 gates low sources.
// - Flag, enable and global enable all set means vector at once.
// - Priority mode enable resets cleared; legacy mode ignores priority bits.
// - Legacy: bit 6 gates peripherals, bit 7 gates all, vector 0008h.
// - Accepting clears the governing global enable for the accepted level.
// - Accepting pushes return address and loads vector into the counter.
// - Return-from-interrupt sets again the applicable global enable.
// - Pin and port-change latency to vector is three to four cycles.
// - Flags set on events whatever the enables, for software polling.
// - Clearing one source enable stops only that source from vectoring.
// - Port-change flag sets on upper port pin change, holds while mismatched.
// - Edge select set means rising edge sets flag, clear means falling.
package tlic_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int NSRC = 16;
  localparam int NPER = 8;
  localparam int NEXT = 4;
  localparam int PC_W = 21;
  // Register word offsets (byte address / 4)
  localparam logic [ADDR_W-1:0] REG_IRQ_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_RESET_CTRL = 4'h1;
  localparam logic [ADDR_W-1:0] REG_FLAGS = 4'h2;
  localparam logic [ADDR_W-1:0] REG_ENABLES = 4'h3;
  localparam logic [ADDR_W-1:0] REG_PRIORITY = 4'h4;
  localparam logic [ADDR_W-1:0] REG_EDGE_SEL = 4'h5;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h6;
  // Control bit positions
  localparam int HIGH_EN_BIT = 7;
  localparam int LOW_EN_BIT = 6;
  localparam int PRIO_MODE_BIT = 7;
  // Source indices: core sources low, peripherals from SRC_PER0
  localparam int SRC_TMR0 = 0;
  localparam int SRC_EXT0 = 1;
  localparam int SRC_PCHG = 5;
  localparam int SRC_PER0 = 8;
  localparam logic [PC_W-1:0] VEC_HIGH = 21'h000008;
  localparam logic [PC_W-1:0] VEC_LOW = 21'h000018;
  localparam logic [NEXT-1:0] EDGE_RST = 4'hf;
  localparam logic [NSRC-1:0] PRIO_RST = 16'h00ff;
  // Pin events: two sync stages plus flag gives three cycles to request
  localparam int SYNC_STAGES = 2;
  localparam logic [1:0] SVC_NONE = 2'h0;
  typedef enum logic [1:0] {
    TLIC_RUN,
    TLIC_SVC_LOW,
    TLIC_SVC_HIGH
  } tlic_level_t;
endpackage

/* tlic_top.sv */
// Two-level interrupt controller with Avalon-MM register slave
//
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module tlic_top
  import tlic_pkg::*;
(
  input wire logic clk, // Core clock 40 MHz
  input wire logic srst, // Sync reset, high
  input wire logic ce, // Clock enable
  input wire logic [ADDR_W-1:0] avs_address, // Word address
  input wire logic avs_read, // Read strobe
  input wire logic avs_write, // Write strobe
  input wire logic [DATA_W-1:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [DATA_W-1:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Wait request
  input wire logic [NEXT-1:0] ext_pin, // External irq pins
  input wire logic [3:0] port_upper, // Upper port pins
  input wire logic port_read, // Port read ends mismatch
  input wire logic timer_zero_ovf, // Timer zero pulse
  input wire logic [NPER-1:0] periph_evt, // Peripheral pulses
  input wire logic [PC_W-1:0] ret_addr, // Address to push
  input wire logic instr_done, // Instruction boundary
  input wire logic return_from_irq_instr, // Return executed
  output logic irq_take, // Vector now, pulse
  output logic [PC_W-1:0] vector_addr, // Vector address
  output logic stack_push, // Push return addr
  output logic [PC_W-1:0] stack_data, // Pushed address
  output logic wake_req // Wake from idle/sleep
);
  logic [7:0] irq_control_reg_ff;
  logic priority_mode_enable_ff;
  logic [NSRC-1:0] flag_ff;
  logic [NSRC-1:0] en_ff;
  logic [NSRC-1:0] prio_ff;
  logic [NEXT-1:0] edge_sel_ff;
  logic [3:0] port_last_ff;
  logic [3:0] port_sync_ff;
  logic [3:0] port_sync2_ff;
  tlic_level_t level_ff;
  tlic_level_t nxt_level;
  logic low_active_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic [NEXT-1:0] ext_evt;
  logic [NSRC-1:0] evt;
  logic [NSRC-1:0] sw_clr;
  logic [NSRC-1:0] sw_set;
  logic req_high;
  logic req_low;
  logic take_high;
  logic take_low;
  logic global_irq_enable;
  logic peripheral_irq_enable;
  logic wr_hit;

  function automatic logic [NSRC-1:0] merge16(input logic [NSRC-1:0] old,
      input logic [DATA_W-1:0] d, input logic [3:0] be);
    logic [NSRC-1:0] r;
    r = old;
    if (be[0]) r[7:0] = d[7:0];
    if (be[1]) r[15:8] = d[15:8];
    return r;
  endfunction

  assign global_irq_enable = irq_control_reg_ff[HIGH_EN_BIT];
  assign peripheral_irq_enable = irq_control_reg_ff[LOW_EN_BIT];

  genvar gi;
  generate
    for (gi = 0; gi < NEXT; gi++) begin : g_ext
      tlic_edge_det u_edge (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .pin(ext_pin[gi]),
        .rise_sel(edge_sel_ff[gi]),
        .edge_pulse(ext_evt[gi])
      );
    end
  endgenerate

  // Port change detect; mismatch held until a port read refreshes latch
  always_ff @(posedge clk) begin
    if (srst) begin
      port_sync_ff <= '0;
      port_sync2_ff <= '0;
      port_last_ff <= '0;
    end else if (ce) begin
      port_sync_ff <= port_upper;
      port_sync2_ff <= port_sync_ff;
      if (port_read)
        port_last_ff <= port_sync2_ff;
    end
  end

  always_comb begin
    evt = '0;
    evt[SRC_TMR0] = timer_zero_ovf;
    evt[SRC_EXT0 +: NEXT] = ext_evt;
    evt[SRC_PCHG] = |(port_sync2_ff ^ port_last_ff);
    evt[SRC_PER0 +: NPER] = periph_evt;
  end

  assign wr_hit = avs_write & ~avs_waitrequest;

  always_comb begin
    sw_clr = '0;
    sw_set = '0;
    if (wr_hit && avs_address == REG_FLAGS) begin
      sw_set = merge16(flag_ff, avs_writedata, avs_byteenable) & ~flag_ff;
      sw_clr = ~merge16(flag_ff, avs_writedata, avs_byteenable) & flag_ff;
    end
  end

  // Events set flags whatever the enables; set wins over clear
  always_ff @(posedge clk) begin
    if (srst)
      flag_ff <= '0;
    else if (ce)
      flag_ff <= ((flag_ff & ~sw_clr) | sw_set) | evt;
  end

  // Request qualification per level
  always_comb begin
    logic [NSRC-1:0] act;
    logic [NSRC-1:0] gate;
    act = flag_ff & en_ff;
    gate = '1;
    req_high = 1'b0;
    req_low = 1'b0;
    if (priority_mode_enable_ff) begin
      req_high = global_irq_enable & |(act & prio_ff);
      req_low = peripheral_irq_enable & |(act & ~prio_ff);
    end else begin
      gate[SRC_PER0 +: NPER] = {NPER{peripheral_irq_enable}};
      req_high = global_irq_enable & |(act & gate);
    end
  end

  // High preempts low; low waits for high service to end
  assign take_high = req_high & instr_done & (level_ff != TLIC_SVC_HIGH);
  assign take_low = req_low & instr_done & ~take_high &
    (level_ff == TLIC_RUN);

  always_comb begin
    nxt_level = level_ff;
    if (take_high)
      nxt_level = TLIC_SVC_HIGH;
    else if (take_low)
      nxt_level = TLIC_SVC_LOW;
    else if (return_from_irq_instr) begin
      case (level_ff)
        TLIC_SVC_HIGH: nxt_level = low_active_ff ? TLIC_SVC_LOW : TLIC_RUN;
        TLIC_SVC_LOW: nxt_level = TLIC_RUN;
        default: nxt_level = TLIC_RUN;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      level_ff <= TLIC_RUN;
      low_active_ff <= 1'b0;
    end else if (ce) begin
      level_ff <= nxt_level;
      if (take_high)
        low_active_ff <= (level_ff == TLIC_SVC_LOW);
      else if (take_low)
        low_active_ff <= 1'b0;
    end
  end

  // Control register: hardware clears on entry, sets on return
  always_ff @(posedge clk) begin
    if (srst)
      irq_control_reg_ff <= '0;
    else if (ce) begin
      if (wr_hit && avs_address == REG_IRQ_CTRL && avs_byteenable[0])
        irq_control_reg_ff <= avs_writedata[7:0];
      if (take_high)
        irq_control_reg_ff[HIGH_EN_BIT] <= 1'b0;
      else if (take_low)
        irq_control_reg_ff[LOW_EN_BIT] <= 1'b0;
      else if (return_from_irq_instr) begin
        if (!priority_mode_enable_ff || level_ff == TLIC_SVC_HIGH)
          irq_control_reg_ff[HIGH_EN_BIT] <= 1'b1;
        else
          irq_control_reg_ff[LOW_EN_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      priority_mode_enable_ff <= 1'b0;
      en_ff <= '0;
      prio_ff <= PRIO_RST;
      edge_sel_ff <= EDGE_RST;
    end else if (ce && wr_hit) begin
      case (avs_address)
        REG_RESET_CTRL: if (avs_byteenable[0])
          priority_mode_enable_ff <= avs_writedata[PRIO_MODE_BIT];
        REG_ENABLES: en_ff <= merge16(en_ff, avs_writedata, avs_byteenable);
        REG_PRIORITY:
          prio_ff <= merge16(prio_ff, avs_writedata, avs_byteenable);
        REG_EDGE_SEL: if (avs_byteenable[0])
          edge_sel_ff <= avs_writedata[NEXT-1:0];
        default: ;
      endcase
    end
  end

  // Core handoff: vector, push and wake all registered
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_take <= 1'b0;
      vector_addr <= VEC_HIGH;
      stack_push <= 1'b0;
      stack_data <= '0;
      wake_req <= 1'b0;
    end else if (ce) begin
      irq_take <= take_high | take_low;
      stack_push <= take_high | take_low;
      if (take_high | take_low) begin
        vector_addr <= take_high ? VEC_HIGH : VEC_LOW;
        stack_data <= ret_addr;
      end
      wake_req <= |(flag_ff & en_ff);
    end
  end

  always_comb begin
    nxt_rdata = '0;
    case (avs_address)
      REG_IRQ_CTRL: nxt_rdata[7:0] = irq_control_reg_ff;
      REG_RESET_CTRL: nxt_rdata[PRIO_MODE_BIT] = priority_mode_enable_ff;
      REG_FLAGS: nxt_rdata[NSRC-1:0] = flag_ff;
      REG_ENABLES: nxt_rdata[NSRC-1:0] = en_ff;
      REG_PRIORITY: nxt_rdata[NSRC-1:0] = prio_ff;
      REG_EDGE_SEL: nxt_rdata[NEXT-1:0] = edge_sel_ff;
      REG_STATUS: nxt_rdata[1:0] = level_ff;
      default: nxt_rdata = '0;
    endcase
  end

  // One wait cycle per access: request seen, then answered next edge
  always_ff @(posedge clk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end else if (ce) begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (avs_read && avs_waitrequest)
        avs_readdata <= nxt_rdata;
    end
  end

  // Vectoring, levels, enables and flags
  a_high_vector: assert property (@(posedge clk) disable iff (srst)
    ce && take_high |=> irq_take && vector_addr == VEC_HIGH)
    else $error("high vector wrong");
  a_low_vector: assert property (@(posedge clk) disable iff (srst)
    ce && take_low |=> vector_addr == VEC_LOW)
    else $error("low vector wrong");
  a_no_low_in_high: assert property (@(posedge clk)
    disable iff (srst) level_ff == TLIC_SVC_HIGH |-> !take_low)
    else $error("low taken during high service");
  a_high_level: assert property (@(posedge clk) disable iff (srst)
    ce && take_high |=> level_ff == TLIC_SVC_HIGH)
    else $error("high level not entered");
  a_low_level: assert property (@(posedge clk) disable iff (srst)
    ce && take_low |=> level_ff == TLIC_SVC_LOW)
    else $error("low level not entered");
  a_legacy_high: assert property (@(posedge clk) disable iff (srst)
    !priority_mode_enable_ff |-> !take_low)
    else $error("low vector in legacy mode");
  a_high_cleared: assert property (@(posedge clk) disable iff (srst)
    ce && take_high |=> !irq_control_reg_ff[HIGH_EN_BIT])
    else $error("global enable not cleared");
  a_low_cleared: assert property (@(posedge clk) disable iff (srst)
    ce && take_low |=> !irq_control_reg_ff[LOW_EN_BIT])
    else $error("low enable not cleared");
  a_gate_global: assert property (@(posedge clk) disable iff (srst)
    !global_irq_enable |-> !take_high)
    else $error("high taken while disabled");
  a_low_gated: assert property (@(posedge clk) disable iff (srst)
    priority_mode_enable_ff && !peripheral_irq_enable |-> !take_low)
    else $error("low taken while disabled");
  a_need_enable: assert property (@(posedge clk) disable iff (srst)
    !(|(flag_ff & en_ff)) |-> !take_high && !take_low)
    else $error("vector without enabled flag");
  a_periph_gate: assert property (@(posedge clk) disable iff (srst)
    !priority_mode_enable_ff && !peripheral_irq_enable &&
    !(|(flag_ff[SRC_PER0-1:0] & en_ff[SRC_PER0-1:0])) |-> !take_high)
    else $error("peripheral passed the legacy gate");
  a_push_pair: assert property (@(posedge clk) disable iff (srst)
    irq_take |-> stack_push && stack_data == $past(ret_addr))
    else $error("push missing on vector");
  a_ret_restore: assert property (@(posedge clk) disable iff (srst)
    ce && return_from_irq_instr && !take_high && !take_low &&
    !priority_mode_enable_ff |=> global_irq_enable)
    else $error("return did not restore enable");
  a_ret_unwind: assert property (@(posedge clk) disable iff (srst)
    ce && return_from_irq_instr && !take_high && !take_low &&
    level_ff == TLIC_SVC_LOW |=> level_ff == TLIC_RUN)
    else $error("return did not leave low level");
  a_flag_sets: assert property (@(posedge clk) disable iff (srst)
    ce && timer_zero_ovf |=> flag_ff[SRC_TMR0])
    else $error("flag not set on event");
  a_pchg_flag: assert property (@(posedge clk) disable iff (srst)
    ce && port_sync2_ff != port_last_ff |=> flag_ff[SRC_PCHG])
    else $error("port change flag not set");
  a_mode_reset: assert property (@(posedge clk)
    $past(srst) |-> !priority_mode_enable_ff)
    else $error("priority mode not reset");
  a_wake_req: assert property (@(posedge clk) disable iff (srst)
    ce && |(flag_ff & en_ff) |=> wake_req)
    else $error("wake not requested");
  a_wake_clear: assert property (@(posedge clk) disable iff (srst)
    ce && !(|(flag_ff & en_ff)) |=> !wake_req)
    else $error("wake held without request");
  // Bus handshake and clock-enable freeze
  a_wait_answer: assert property (@(posedge clk) disable iff (srst)
    ce && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered");
  a_wait_idle: assert property (@(posedge clk) disable iff (srst)
    ce && !avs_waitrequest |=> avs_waitrequest)
    else $error("wait request low twice");
  a_ce_freeze: assert property (@(posedge clk) disable iff (srst)
    !ce |=> $stable(flag_ff) && $stable(level_ff))
    else $error("state moved while frozen");
  // Main scenarios
  c_high_take: cover property (@(posedge clk) take_high);
  c_low_take: cover property (@(posedge clk) take_low);
  c_preempt: cover property (@(posedge clk)
    level_ff == TLIC_SVC_LOW && take_high);
  c_return: cover property (@(posedge clk) return_from_irq_instr &&
    level_ff != TLIC_RUN);
  c_pin_take: cover property (@(posedge clk)
    take_high && flag_ff[SRC_EXT0]);
endmodule
`default_nettype wire

/* tlic_top_tb.sv */
// Self-checking bench for the two-level interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tlic_top_tb
  import tlic_pkg::*;
;
  logic clk, srst, ce, avs_read, avs_write, port_read, timer_zero_ovf;
  logic slow, ret_req, avs_waitrequest, irq_take, stack_push, wake_req;
  logic instr_done, ret_pulse;
  logic [ADDR_W-1:0] avs_address;
  logic [DATA_W-1:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable, port_upper;
  logic [NEXT-1:0] ext_pin;
  logic [NPER-1:0] periph_evt;
  logic [PC_W-1:0] ret_addr, vector_addr, stack_data, last_vec, prev_ret;
  int error_cnt = 0;
  int checked = 0;
  int takes = 0;
  int n;
  tlic_top uut (.clk(clk), .srst(srst), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ext_pin(ext_pin), .port_upper(port_upper), .port_read(port_read),
    .timer_zero_ovf(timer_zero_ovf), .periph_evt(periph_evt),
    .ret_addr(ret_addr), .instr_done(instr_done),
    .return_from_irq_instr(ret_pulse), .irq_take(irq_take),
    .vector_addr(vector_addr), .stack_push(stack_push),
    .stack_data(stack_data), .wake_req(wake_req));
  tlic_core_model core (.clk(clk), .srst(srst), .slow(slow),
    .ret_req(ret_req), .irq_take(irq_take), .vector_addr(vector_addr),
    .instr_done(instr_done), .ret_addr(ret_addr), .ret_pulse(ret_pulse));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (error_cnt == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Takes are pulses, so count them wherever the bench happens to be
  always @(posedge clk) begin
    if (irq_take === 1'b1) begin
      takes++;
      last_vec = vector_addr;
      chk({31'h0, stack_push}, 32'h1);
      chk({11'h0, stack_data}, {11'h0, prev_ret});
    end
    prev_ret = ret_addr;
  end
  task automatic bus(input logic wr, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int k;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 40);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      error_cnt++;
      wrap_up();
    end else
      @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic evt(input logic [7:0] p, input logic t);
    periph_evt <= p;
    timer_zero_ovf <= t;
    @(posedge clk);
    periph_evt <= 8'h00;
    timer_zero_ovf <= 1'b0;
  endtask
  task automatic ret();
    ret_req <= 1'b1;
    @(posedge clk);
    ret_req <= 1'b0;
    tick(8);
  endtask
  task automatic took(input int cnt, input logic [PC_W-1:0] vec);
    tick(8);
    chk(takes, cnt);
    chk({11'h0, last_vec}, {11'h0, vec});
  endtask
  initial begin
    srst = 1'b1;
    ce = 1'b1;
    {avs_read, avs_write, port_read, timer_zero_ovf, slow, ret_req} = '0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    port_upper = 4'h0;
    ext_pin = 4'h0;
    periph_evt = 8'h00;
    tick(6);
    srst <= 1'b0;
    tick(1);
    rdc(REG_IRQ_CTRL, 32'h0);
    rdc(REG_RESET_CTRL, 32'h0);
    rdc(REG_PRIORITY, 32'h00ff);
    rdc(REG_EDGE_SEL, 32'hf);
    rdc(REG_STATUS, 32'h0);
    wr(4'hf, 32'hffffffff);
    rdc(4'hf, 32'h0);
    // Legacy mode, core sources
    wr(REG_ENABLES, 32'h0002);
    wr(REG_IRQ_CTRL, 32'hc0);
    evt(8'h00, 1'b1);
    rdc(REG_FLAGS, 32'h0001);
    chk({31'h0, wake_req}, 32'h0);
    chk(takes, 0);
    wr(REG_IRQ_CTRL, 32'h0);
    wr(REG_ENABLES, 32'h0001);
    tick(1);
    chk({31'h0, wake_req}, 32'h1);
    tick(8);
    chk(takes, 0);
    slow <= 1'b1;
    wr(REG_IRQ_CTRL, 32'h80);
    took(1, VEC_HIGH);
    rdc(REG_IRQ_CTRL, 32'h0);
    wr(REG_FLAGS, 32'h0);
    ret();
    rdc(REG_IRQ_CTRL, 32'h80);
    // Legacy peripheral gate; priority bits ignored
    wr(REG_ENABLES, 32'h0100);
    evt(8'h01, 1'b0);
    tick(8);
    chk(takes, 1);
    rdc(REG_FLAGS, 32'h0100);
    wr(REG_IRQ_CTRL, 32'hc0);
    took(2, VEC_HIGH);
    rdc(REG_IRQ_CTRL, 32'h40);
    wr(REG_FLAGS, 32'h0);
    ret();
    slow <= 1'b0;
    // Two-level mode: low first, then high preempts
    wr(REG_RESET_CTRL, 32'h80);
    rdc(REG_RESET_CTRL, 32'h80);
    wr(REG_IRQ_CTRL, 32'h40);
    wr(REG_ENABLES, 32'h0101);
    evt(8'h01, 1'b0);
    took(3, VEC_LOW);
    rdc(REG_IRQ_CTRL, 32'h0);
    rdc(REG_STATUS, 32'h1);
    evt(8'h00, 1'b1);
    tick(8);
    chk(takes, 3);
    wr(REG_IRQ_CTRL, 32'h80);
    took(4, VEC_HIGH);
    rdc(REG_STATUS, 32'h2);
    wr(REG_IRQ_CTRL, 32'h40);
    tick(10);
    chk(takes, 4);
    wr(REG_FLAGS, 32'h0);
    ret();
    rdc(REG_IRQ_CTRL, 32'hc0);
    rdc(REG_STATUS, 32'h1);
    ret();
    rdc(REG_STATUS, 32'h0);
    // Pin latency on a rising edge
    wr(REG_ENABLES, 32'h0002);
    ext_pin <= 4'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (irq_take !== 1'b1 && n < 10);
    chk({31'h0, (n >= 4 && n <= 5)}, 32'h1);
    wr(REG_ENABLES, 32'h0);
    wr(REG_FLAGS, 32'h0);
    ret();
    // Falling-edge select, then port mismatch
    wr(REG_EDGE_SEL, 32'he);
    ext_pin <= 4'h0;
    tick(6);
    rdc(REG_FLAGS, 32'h0002);
    wr(REG_FLAGS, 32'h0);
    ext_pin <= 4'h1;
    tick(6);
    rdc(REG_FLAGS, 32'h0);
    port_upper <= 4'h4;
    tick(6);
    rdc(REG_FLAGS, 32'h0020);
    wr(REG_FLAGS, 32'h0);
    rdc(REG_FLAGS, 32'h0020);
    port_read <= 1'b1;
    @(posedge clk);
    port_read <= 1'b0;
    tick(2);
    wr(REG_FLAGS, 32'h0);
    rdc(REG_FLAGS, 32'h0);
    // Clock enable low must drop a timer pulse entirely
    ce <= 1'b0;
    evt(8'h00, 1'b1);
    tick(2);
    ce <= 1'b1;
    rdc(REG_FLAGS, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
